// *** verilog/qenc_defs.vh ***
// register indices, field positions, reset values and decimal modulus of the encoder block
`ifndef QENC_DEFS_VH
`define QENC_DEFS_VH

// register indices; byte address is index times four
`define QE_IDX_CFG 6'h38
`define QE_IDX_POS 6'h39
`define QE_IDX_CONST 6'h3a
`define QE_IDX_STATUS 6'h3b
`define QE_IDX_CAPT 6'h3c
`define QE_IDX_RAMP_CAPT 6'h3d
`define QE_IDX_IRQ_MASK 6'h3e

// configuration field positions
`define QE_CFG_POL_A 0
`define QE_CFG_POL_B 1
`define QE_CFG_POL_N 2
`define QE_CFG_SKIP_AB 3
`define QE_CFG_CONT 4
`define QE_CFG_ONCE 5
`define QE_CFG_POS_EDGE 6
`define QE_CFG_NEG_EDGE 7
`define QE_CFG_CLEAR 8
`define QE_CFG_RAMP_CAPT 9
`define QE_CFG_DECIMAL 10
`define QE_CFG_W 11

// status field positions
`define QE_STAT_INDEX 0

// reset values
`define QE_CFG_RST 11'h000
`define QE_CONST_RST 32'h0000_0000
`define QE_POS_RST 32'h0000_0000
`define QE_MASK_RST 1'h1

// fractional modulus in decimal mode
`define QE_DEC_MOD 17'h02710

`endif

// *** verilog/pin_sync3.v ***
// three-stage pin synchroniser with agreement filter, one lane per bit
`timescale 1ns/1ps

module pin_sync3 #(
   parameter W = 3
) (
   input wire i_ref_clk,
   input wire i_rst_n,
   input wire [W-1:0] i_pin,
   output wire [W-1:0] o_level
);

   // ---------------------------------------------------------------
   // per-bit synchroniser lanes
   // ---------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < W; g = g + 1) begin : lane
         reg s1_q;
         reg s2_q;
         reg s3_q;
         reg lvl_q;
         // stage one feeds stage two only; level moves once two and three agree
         always @(posedge i_ref_clk or negedge i_rst_n) begin
            if (!i_rst_n) begin
               s1_q <= 1'b0;
               s2_q <= 1'b0;
               s3_q <= 1'b0;
               lvl_q <= 1'b0;
            end else begin
               s1_q <= i_pin[g];
               s2_q <= s1_q;
               s3_q <= s2_q;
               if (s2_q == s3_q) begin
                  lvl_q <= s3_q;
               end
            end
         end
         assign o_level[g] = lvl_q;
      end
   endgenerate

endmodule // pin_sync3

// *** verilog/step_accum.v ***
// fixed-point position accumulator with binary or decimal fraction
`timescale 1ns/1ps
`include "qenc_defs.vh"

module step_accum (
   input wire i_ref_clk,
   input wire i_rst_n,
   input wire i_step,
   input wire i_up,
   input wire i_decimal,
   input wire [31:0] i_const,
   input wire i_load,
   input wire [31:0] i_load_val,
   input wire i_clear,
   output wire [31:0] o_pos
);

   reg [31:0] pos_q;
   reg [31:0] pos_d;
   reg [15:0] frac_q;
   reg [15:0] frac_d;
   wire [16:0] sum17;
   wire [16:0] diff17;
   wire [31:0] int_se;
   wire [16:0] sum_wrap;
   wire [16:0] diff_wrap;
   reg carry;

   // ---------------------------------------------------------------
   // fraction arithmetic
   // ---------------------------------------------------------------
   // integer part is signed, fraction is an unsigned remainder
   assign int_se = {{16{i_const[31]}}, i_const[31:16]};
   assign sum17 = {1'b0, frac_q} + {1'b0, i_const[15:0]};
   assign diff17 = {1'b0, frac_q} - {1'b0, i_const[15:0]};
   // decimal wrap terms; only the low sixteen bits are kept as the fraction
   assign sum_wrap = sum17 - `QE_DEC_MOD;
   assign diff_wrap = diff17 + `QE_DEC_MOD;

   // next value: load beats clear beats step
   always @* begin
      pos_d = pos_q;
      frac_d = frac_q;
      carry = 1'b0;
      if (i_load) begin
         pos_d = i_load_val;
         frac_d = 16'h0000;
      end else if (i_clear) begin
         pos_d = `QE_POS_RST;
         frac_d = 16'h0000;
      end else if (i_step && i_up) begin
         if (i_decimal && sum17 >= `QE_DEC_MOD) begin
            carry = 1'b1;
            frac_d = sum_wrap[15:0];
         end else begin
            carry = sum17[16] & ~i_decimal;
            frac_d = sum17[15:0];
         end
         pos_d = pos_q + int_se + {31'h0000_0000, carry};
      end else if (i_step) begin
         carry = diff17[16];
         if (i_decimal && diff17[16]) begin
            frac_d = diff_wrap[15:0];
         end else begin
            frac_d = diff17[15:0];
         end
         pos_d = pos_q - int_se - {31'h0000_0000, carry};
      end
   end

   // position and fraction state
   always @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         pos_q <= `QE_POS_RST;
         frac_q <= 16'h0000;
      end else begin
         pos_q <= pos_d;
         frac_q <= frac_d;
      end
   end

   assign o_pos = pos_q;

endmodule // step_accum

// *** verilog/quadrature_encoder_interface.v ***
// incremental a/b/n encoder interface: decoder, index logic and registers
`timescale 1ns/1ps
// -------------------------------------------------------------------
// Contract
// - signed 32-bit position, readable and writable
// - step constant 16.16 signed, resets zero
// - each step adds or subtracts constant
// - config bit 10 picks decimal fraction
// - index event sets status, read clears
// - status bit drives interrupt output
// - index event copies position to capture
// - config bit 9 also captures ramp position
// - config bit 8 clears position after capture
// - bits 7:6 choose level or edge sensitivity
// - bit 5 acts on first event only
// - bit 4 acts on every event
// - bit 3 drops a/b qualification
// - bit 2 sets index active level
// - bits 1:0 give required b/a levels
// -------------------------------------------------------------------
`include "qenc_defs.vh"

module quadrature_encoder_interface #(
   parameter ADDR_W = 8
) (
   input wire i_ref_clk,
   input wire i_rst_n,
   input wire i_enc_a,
   input wire i_enc_b,
   input wire i_enc_n,
   input wire [31:0] i_ramp_actual_position,
   input wire [ADDR_W-1:0] i_addr,
   input wire [31:0] i_wr_data,
   input wire i_wr_en,
   input wire i_rd_en,
   output wire [31:0] o_rd_data,
   output wire o_irq,
   output wire o_index_event
);

   // -------------------------------------------------------------------
   // declarations
   // -------------------------------------------------------------------
   reg [`QE_CFG_W-1:0] encoder_configuration_q;
   reg [31:0] encoder_step_constant_q;
   reg [31:0] index_capture_position_q;
   reg [31:0] ramp_capture_position_q;
   reg encoder_event_status_q;
   reg encoder_event_status_d;
   reg irq_mask_q;
   reg irq_q;
   reg [31:0] rd_data_q;
   reg [31:0] rd_mux;
   reg index_event_q;
   reg once_armed_q;
   reg a_prev_q;
   reg b_prev_q;
   reg cond_prev_q;
   wire [2:0] pin_level;
   wire a_lvl;
   wire b_lvl;
   wire n_lvl;
   wire [31:0] enc_pos;
   wire sel_cfg;
   wire sel_pos;
   wire sel_const;
   wire sel_status;
   wire sel_capt;
   wire sel_ramp_capt;
   wire sel_mask;
   wire wr_cfg;
   wire wr_pos;
   wire wr_const;
   wire wr_status;
   wire wr_mask;
   wire rd_status;
   wire a_chg;
   wire b_chg;
   wire step;
   wire step_up;
   wire n_active;
   wire ab_match;
   wire index_cond;
   wire cond_rise;
   wire cond_fall;
   reg index_event;
   wire fire;
   wire clear_pos;

   // -------------------------------------------------------------------
   // address decode
   // -------------------------------------------------------------------
   // registers sit one per word; low two address bits must be zero
   assign sel_cfg = (i_addr == {`QE_IDX_CFG, 2'b00});
   assign sel_pos = (i_addr == {`QE_IDX_POS, 2'b00});
   assign sel_const = (i_addr == {`QE_IDX_CONST, 2'b00});
   assign sel_status = (i_addr == {`QE_IDX_STATUS, 2'b00});
   assign sel_capt = (i_addr == {`QE_IDX_CAPT, 2'b00});
   assign sel_ramp_capt = (i_addr == {`QE_IDX_RAMP_CAPT, 2'b00});
   assign sel_mask = (i_addr == {`QE_IDX_IRQ_MASK, 2'b00});

   // write and read qualifiers
   assign wr_cfg = i_wr_en & sel_cfg;
   assign wr_pos = i_wr_en & sel_pos;
   assign wr_const = i_wr_en & sel_const;
   assign wr_status = i_wr_en & sel_status;
   assign wr_mask = i_wr_en & sel_mask;
   assign rd_status = i_rd_en & sel_status;

   // -------------------------------------------------------------------
   // software-written registers
   // -------------------------------------------------------------------
   // configuration, step constant and interrupt mask
   always @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         encoder_configuration_q <= `QE_CFG_RST;
         encoder_step_constant_q <= `QE_CONST_RST;
         irq_mask_q <= `QE_MASK_RST;
      end else begin
         if (wr_cfg) begin
            encoder_configuration_q <= i_wr_data[`QE_CFG_W-1:0];
         end
         if (wr_const) begin
            encoder_step_constant_q <= i_wr_data;
         end
         if (wr_mask) begin
            irq_mask_q <= i_wr_data[0];
         end
      end
   end

   // -------------------------------------------------------------------
   // pin synchronisation
   // -------------------------------------------------------------------
   // all three encoder lines come from off chip
   pin_sync3 #(
      .W(3)
   ) u_pin_sync (
      .i_ref_clk(i_ref_clk),
      .i_rst_n(i_rst_n),
      .i_pin({i_enc_n, i_enc_b, i_enc_a}),
      .o_level(pin_level)
   );

   // filtered levels; bit order matches the concatenation above
   assign a_lvl = pin_level[0];
   assign b_lvl = pin_level[1];
   assign n_lvl = pin_level[2];

   // -------------------------------------------------------------------
   // quadrature decode
   // -------------------------------------------------------------------
   // previous filtered a/b levels
   always @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         a_prev_q <= 1'b0;
         b_prev_q <= 1'b0;
      end else begin
         a_prev_q <= a_lvl;
         b_prev_q <= b_lvl;
      end
   end

   // one step per single-line change; a double change is lost, not guessed
   assign a_chg = a_lvl ^ a_prev_q;
   assign b_chg = b_lvl ^ b_prev_q;
   assign step = a_chg ^ b_chg;
   // a leading b counts up: 00 -> 10 -> 11 -> 01 -> 00
   assign step_up = a_lvl ^ b_prev_q;

   // -------------------------------------------------------------------
   // index qualification
   // -------------------------------------------------------------------
   // index active level follows the configured polarity
   assign n_active = ~(n_lvl ^ encoder_configuration_q[`QE_CFG_POL_N]);

   // a and b must sit at their configured levels unless skipped
   assign ab_match = encoder_configuration_q[`QE_CFG_SKIP_AB] |
      ((a_lvl == encoder_configuration_q[`QE_CFG_POL_A]) &&
      (b_lvl == encoder_configuration_q[`QE_CFG_POL_B]));

   assign index_cond = n_active & ab_match;

   // previous qualified condition for edge detection
   always @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         cond_prev_q <= 1'b0;
      end else begin
         cond_prev_q <= index_cond;
      end
   end

   assign cond_rise = index_cond & ~cond_prev_q;
   assign cond_fall = ~index_cond & cond_prev_q;

   // edges are of the qualified condition, so an a/b move can make one too
   // sensitivity select; level mode fires every cycle while active
   always @* begin
      case ({encoder_configuration_q[`QE_CFG_NEG_EDGE],
            encoder_configuration_q[`QE_CFG_POS_EDGE]})
         2'b00: begin
            index_event = index_cond;
         end
         2'b01: begin
            index_event = cond_rise;
         end
         2'b10: begin
            index_event = cond_fall;
         end
         2'b11: begin
            index_event = cond_rise | cond_fall;
         end
         default: begin
            index_event = 1'b0;
         end
      endcase
   end

   // -------------------------------------------------------------------
   // capture control
   // -------------------------------------------------------------------
   // single-shot arming; a new config write re-arms or disarms it
   always @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         once_armed_q <= 1'b0;
      end else if (wr_cfg) begin
         once_armed_q <= i_wr_data[`QE_CFG_ONCE];
      end else if (index_event) begin
         once_armed_q <= 1'b0;
      end
   end

   // capture fires on every event or the first after arming
   // level mode with continuous capture rewrites the capture every cycle
   assign fire = index_event &
      (encoder_configuration_q[`QE_CFG_CONT] | once_armed_q);

   // clear counter only when the action bit asks for it
   assign clear_pos = fire & encoder_configuration_q[`QE_CFG_CLEAR];

   // capture takes the pre-clear position of this same cycle
   always @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         index_capture_position_q <= 32'h0000_0000;
         ramp_capture_position_q <= 32'h0000_0000;
      end else if (fire) begin
         index_capture_position_q <= enc_pos;
         if (encoder_configuration_q[`QE_CFG_RAMP_CAPT]) begin
            ramp_capture_position_q <= i_ramp_actual_position;
         end
      end
   end

   // -------------------------------------------------------------------
   // position accumulator
   // -------------------------------------------------------------------
   // software write beats index clear beats counting
   step_accum u_step_accum (
      .i_ref_clk(i_ref_clk),
      .i_rst_n(i_rst_n),
      .i_step(step),
      .i_up(step_up),
      .i_decimal(encoder_configuration_q[`QE_CFG_DECIMAL]),
      .i_const(encoder_step_constant_q),
      .i_load(wr_pos),
      .i_load_val(i_wr_data),
      .i_clear(clear_pos),
      .o_pos(enc_pos)
   );

   // -------------------------------------------------------------------
   // event status and interrupt
   // -------------------------------------------------------------------
   // a read that meets a new event returns the old value, so nothing is lost
   // sticky flag: set wins over read clear and write-one clear
   always @* begin
      encoder_event_status_d = encoder_event_status_q;
      if (rd_status | (wr_status & i_wr_data[`QE_STAT_INDEX])) begin
         encoder_event_status_d = 1'b0;
      end
      if (index_event) begin
         encoder_event_status_d = 1'b1;
      end
   end

   // status, interrupt and event pulse flops
   always @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         encoder_event_status_q <= 1'b0;
         irq_q <= 1'b0;
         index_event_q <= 1'b0;
      end else begin
         encoder_event_status_q <= encoder_event_status_d;
         // driven from the next status so it tracks the flag with no lag while the mask stays set
         irq_q <= encoder_event_status_d & irq_mask_q;
         index_event_q <= index_event;
      end
   end

   // -------------------------------------------------------------------
   // read path
   // -------------------------------------------------------------------
   // unmapped and write-only locations read as zero
   always @* begin
      rd_mux = 32'h0000_0000;
      if (sel_cfg) begin
         rd_mux = {21'h00_0000, encoder_configuration_q};
      end else if (sel_pos) begin
         rd_mux = enc_pos;
      end else if (sel_status) begin
         rd_mux = {31'h0000_0000, encoder_event_status_q};
      end else if (sel_capt) begin
         rd_mux = index_capture_position_q;
      end else if (sel_ramp_capt) begin
         rd_mux = ramp_capture_position_q;
      end else if (sel_mask) begin
         rd_mux = {31'h0000_0000, irq_mask_q};
      end
   end

   // zero between reads so a stale word never looks like an answer
   // read data stands for exactly the cycle after the strobe
   always @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         rd_data_q <= 32'h0000_0000;
      end else if (i_rd_en) begin
         rd_data_q <= rd_mux;
      end else begin
         rd_data_q <= 32'h0000_0000;
      end
   end

   // -------------------------------------------------------------------
   // outputs
   // -------------------------------------------------------------------
   // every output is a flop; no logic between register and pin
   assign o_rd_data = rd_data_q;
   assign o_irq = irq_q;
   assign o_index_event = index_event_q;

endmodule // quadrature_encoder_interface

// *** sim/qenc_chk.sv ***
// port assertions for the encoder interface block
`timescale 1ns/1ps
module qenc_chk #(
   parameter ADDR_W = 8
) (
   input wire i_ref_clk,
   input wire i_rst_n,
   input wire [ADDR_W-1:0] i_addr,
   input wire [31:0] i_wr_data,
   input wire i_wr_en,
   input wire i_rd_en,
   input wire [31:0] o_rd_data,
   input wire o_irq,
   input wire o_index_event
);
   reg [10:0] cfg_q;
   reg mask_q;
   reg [2:0] ev_q;
   // shadow of config and mask, rebuilt from observed writes
   always @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         cfg_q <= 11'h000;
         mask_q <= 1'b1;
         ev_q <= 3'h0;
      end else begin
         ev_q <= {ev_q[1:0], o_index_event};
         if (i_wr_en && i_addr == 8'he0) cfg_q <= i_wr_data[10:0];
         if (i_wr_en && i_addr == 8'hf8) mask_q <= i_wr_data[0];
      end
   end
   // -------------------------------------------------------------
   // properties
   // -------------------------------------------------------------
   default clocking @(posedge i_ref_clk); endclocking
   default disable iff (!i_rst_n);
   sequence cfg_rd;
      i_rd_en && i_addr == 8'he0;
   endsequence
   sequence msk_rd;
      i_rd_en && i_addr == 8'hf8;
   endsequence
   rd_idle_a: assert property (!$past(i_rd_en) |-> o_rd_data == 32'h0)
      else $error("read data not zero outside read slot");
   wo_zero_a: assert property ($past(i_rd_en && (i_addr == 8'he8 || i_addr == 8'h10))
      |-> o_rd_data == 32'h0) else $error("write-only or unmapped read not zero");
   stat_width_a: assert property ($past(i_rd_en && i_addr == 8'hec)
      |-> o_rd_data[31:1] == 31'h0) else $error("status upper bits set");
   cfg_read_a: assert property (cfg_rd |=> o_rd_data == {21'h0, $past(cfg_q)})
      else $error("config readback wrong");
   mask_read_a: assert property (msk_rd |=> o_rd_data == {31'h0, $past(mask_q)})
      else $error("mask readback wrong");
   irq_mask_a: assert property (!mask_q [*3] |-> !o_irq)
      else $error("interrupt while masked");
   irq_cause_a: assert property ($rose(o_irq) && $past(mask_q, 2)
      |-> ev_q != 3'h0 || o_index_event) else $error("interrupt without index event");
   irq_hold_a: assert property (o_irq && mask_q && !i_rd_en && !i_wr_en
      |=> o_irq) else $error("interrupt dropped without clear");
   edge_pulse_a: assert property (o_index_event && cfg_q[7:6] != 2'h0
      |=> !o_index_event) else $error("edge event longer than one cycle");
endmodule // qenc_chk

// *** sim/enc_sensor.sv ***
// behavioural incremental a/b/n encoder sensor
`timescale 1ns/1ps
module enc_sensor (
   input wire i_ref_clk,
   input wire i_rst_n,
   input wire i_fwd,
   input wire i_rev,
   input wire i_index,
   output reg o_a,
   output reg o_b,
   output reg o_n
);
   reg [1:0] ph_q;
   // one gray step per request, never a and b together
   always @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         ph_q <= 2'h0;
      end else if (i_fwd) begin
         ph_q <= ph_q + 2'h1;
      end else if (i_rev) begin
         ph_q <= ph_q - 2'h1;
      end
   end
   // phase to pins, {a,b} walks 00,10,11,01 going forward
   always @* begin
      o_a = (ph_q == 2'h1) || (ph_q == 2'h2);
      o_b = ph_q[1];
      o_n = i_index;
   end
endmodule // enc_sensor

// *** sim/testbench.sv ***
// self-checking bench for the encoder interface block
`timescale 1ns/1ps
`define CHK(g, e) begin samples_checked = samples_checked + 1; \
   if ((g) !== (e)) begin fail_count = fail_count + 1; \
   $display("Error at %0t got %h expected %h", $time, g, e); end end
module testbench;
   reg i_ref_clk = 1'b0;
   reg rst_n = 1'b0;
   reg fwd = 1'b0;
   reg rev = 1'b0;
   reg idx = 1'b1;
   reg [31:0] ramp = 32'h0;
   reg [7:0] addr = 8'h0;
   reg [31:0] wdata = 32'h0;
   reg wr_s = 1'b0;
   reg rd_s = 1'b0;
   wire [31:0] rdata;
   wire irq, iev, pa, pb, pn;
   integer fail_count = 0;
   integer samples_checked = 0;
   integer cyc = 0;
   always #5 i_ref_clk = ~i_ref_clk;
   quadrature_encoder_interface quadrature_encoder_interface_inst (.i_ref_clk(i_ref_clk),
      .i_rst_n(rst_n), .i_enc_a(pa), .i_enc_b(pb), .i_enc_n(pn),
      .i_ramp_actual_position(ramp), .i_addr(addr), .i_wr_data(wdata), .i_wr_en(wr_s),
      .i_rd_en(rd_s), .o_rd_data(rdata), .o_irq(irq), .o_index_event(iev));
   enc_sensor enc_sensor_inst (.i_ref_clk(i_ref_clk), .i_rst_n(rst_n), .i_fwd(fwd),
      .i_rev(rev), .i_index(idx), .o_a(pa), .o_b(pb), .o_n(pn));
   // -------------------------------------------------------------
   // bus and pin tasks
   // -------------------------------------------------------------
   task wait_n(input integer n);
      repeat (n) @(posedge i_ref_clk);
   endtask
   task reg_wr(input [7:0] a, input [31:0] d);
      begin
         @(posedge i_ref_clk);
         addr <= a;
         wdata <= d;
         wr_s <= 1'b1;
         @(posedge i_ref_clk);
         wr_s <= 1'b0;
      end
   endtask
   // data stands only in the cycle after the strobe
   task reg_rd(input [7:0] a, input [31:0] e);
      begin
         @(posedge i_ref_clk);
         addr <= a;
         rd_s <= 1'b1;
         @(posedge i_ref_clk);
         rd_s <= 1'b0;
         #1 `CHK(rdata, e)
      end
   endtask
   // sync plus decode needs about six edges, twelve leaves margin
   task step(input f);
      begin
         @(posedge i_ref_clk);
         if (f) fwd <= 1'b1;
         else rev <= 1'b1;
         @(posedge i_ref_clk);
         fwd <= 1'b0;
         rev <= 1'b0;
         wait_n(12);
      end
   endtask
   // index idles high, active low while pol bit is clear
   task pulse_n;
      begin
         @(posedge i_ref_clk);
         idx <= 1'b0;
         wait_n(12);
         idx <= 1'b1;
         wait_n(12);
      end
   endtask
   task give_verdict;
      begin
         $display("checks %0d mismatches %0d", samples_checked, fail_count);
         if (fail_count == 0 && samples_checked > 0) $display("bench passed");
         else $display("bench failed");
         $finish;
      end
   endtask
   // hang guard, the whole run needs under two thousand cycles
   always @(posedge i_ref_clk) begin
      cyc = cyc + 1;
      if (cyc == 5000) begin
         fail_count = fail_count + 1;
         give_verdict;
      end
   end
   // -------------------------------------------------------------
   // test sequence
   // -------------------------------------------------------------
   initial begin
      wait_n(10);
      rst_n <= 1'b1;
      wait_n(8);
      reg_wr(8'hec, 32'h1); // pin settling may leave a stale event
      reg_rd(8'he0, 32'h0);
      reg_rd(8'he4, 32'h0);
      reg_rd(8'hf8, 32'h1);
      reg_rd(8'hec, 32'h0);
      reg_wr(8'he4, 32'h8000_0001);
      reg_rd(8'he4, 32'h8000_0001);
      reg_wr(8'he8, 32'h1234_5678);
      reg_rd(8'he8, 32'h0);
      reg_rd(8'h10, 32'h0);
      reg_wr(8'hf0, 32'hffff_ffff);
      reg_rd(8'hf0, 32'h0);
      $display("test registers done");
      reg_wr(8'he4, 32'h0);
      reg_wr(8'he8, 32'h0001_8000); // positive sign for forward motion
      step(1);
      step(1);
      reg_rd(8'he4, 32'h3);
      step(0);
      reg_rd(8'he4, 32'h1);
      reg_wr(8'he0, 32'h400);
      reg_wr(8'he4, 32'h0);
      reg_wr(8'he8, 32'h0000_1388);
      step(1);
      step(1);
      reg_rd(8'he4, 32'h1);
      reg_wr(8'he0, 32'h0);
      reg_wr(8'he4, 32'h0);
      step(1);
      step(1);
      reg_rd(8'he4, 32'h0);
      $display("test accumulate done");
      reg_wr(8'he0, 32'h358);
      ramp <= 32'h0abc_def0;
      reg_wr(8'he4, 32'h1234);
      pulse_n;
      `CHK(irq, 1'b1)
      reg_rd(8'hf0, 32'h1234);
      reg_rd(8'he4, 32'h0);
      reg_rd(8'hf4, 32'h0abc_def0);
      reg_rd(8'hec, 32'h1);
      reg_rd(8'hec, 32'h0);
      wait_n(2);
      `CHK(irq, 1'b0)
      reg_wr(8'he4, 32'h55);
      pulse_n;
      reg_rd(8'hf0, 32'h55);
      reg_rd(8'hec, 32'h1);
      reg_wr(8'hf8, 32'h0);
      pulse_n;
      `CHK(irq, 1'b0)
      reg_rd(8'hec, 32'h1);
      reg_wr(8'hf8, 32'h1);
      $display("test capture done");
      reg_wr(8'he0, 32'h068);
      reg_wr(8'he4, 32'h11);
      pulse_n;
      reg_rd(8'hf0, 32'h11);
      reg_rd(8'he4, 32'h11);
      reg_wr(8'he4, 32'h22);
      pulse_n;
      reg_rd(8'hf0, 32'h11);
      reg_wr(8'hec, 32'h1);
      reg_wr(8'he0, 32'h052);
      pulse_n;
      reg_rd(8'hec, 32'h0);
      reg_wr(8'he0, 32'h051);
      pulse_n;
      reg_rd(8'hec, 32'h1);
      $display("test qualify done");
      reg_wr(8'he0, 32'h08c);
      wait_n(8);
      reg_wr(8'hec, 32'h1);
      reg_rd(8'hec, 32'h0);
      idx <= 1'b0;
      wait_n(12);
      reg_rd(8'hec, 32'h1);
      idx <= 1'b1;
      wait_n(12);
      reg_rd(8'hec, 32'h0);
      reg_wr(8'he0, 32'h00c);
      wait_n(8);
      #1 `CHK(iev, 1'b1)
      reg_rd(8'hec, 32'h1);
      idx <= 1'b0;
      wait_n(12);
      reg_wr(8'hec, 32'h1);
      reg_rd(8'hec, 32'h0);
      reg_wr(8'he0, 32'h0c8);
      wait_n(2);
      reg_wr(8'hec, 32'h1);
      reg_rd(8'hec, 32'h0);
      idx <= 1'b1;
      wait_n(12);
      reg_rd(8'hec, 32'h1);
      idx <= 1'b0;
      wait_n(12);
      reg_rd(8'hec, 32'h1);
      $display("test sensitivity done");
      give_verdict;
   end
endmodule // testbench
bind quadrature_encoder_interface qenc_chk #(.ADDR_W(ADDR_W)) qenc_chk_inst (
   .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wr_data(i_wr_data),
   .i_wr_en(i_wr_en), .i_rd_en(i_rd_en), .o_rd_data(o_rd_data), .o_irq(o_irq),
   .o_index_event(o_index_event));
